// ### pfic_firewall.v
`timescale 1ns/1ps
// Notes on behaviour
// RL1: the initiator tag reaches this segment shifted left by one bit compared with other segments.
// RL2: an access is permitted by indexing the membership vector with the doubled tag.
// RL3: on a violation the error log records the doubled tag, not the nominal one.
// RL4: after reset the upper 16 membership bits are zero, admitting only nominal tags below 8.
// RL5: nominal tags 8 or above are denied from reset until the vector is reprogrammed to include them.
// RL6: software programs membership bits and reads logged tags using the doubled tag.
// RL7: nominal tag k maps to membership bit 2k, even positions 0 to 24 only.
// RL8: an access whose bit is clear is blocked from the target and answered with an error.
`include "pfic_consts.vh"

module pfic_firewall #(
    parameter MASK_W = `PFIC_MASK_W,
    parameter [`PFIC_MASK_W-1:0] MASK_RST = `PFIC_MASK_RST
) (
    input wire clk_in, // 20 MHz interconnect clock
    input wire rst_n_in, // async reset, active low
    input wire req_valid_in, // access request from initiator side
    input wire [`PFIC_TAG_W-1:0] req_tag_in, // nominal initiator tag
    input wire [`PFIC_ADDR_W-1:0] req_addr_in, // access address
    input wire req_write_in, // 1 write, 0 read
    input wire [`PFIC_DATA_W-1:0] req_wdata_in, // write data
    input wire mask_wr_in, // load new membership vector
    input wire [MASK_W-1:0] mask_wdata_in, // membership value, indexed by doubled tag
    input wire log_clr_in, // clear the error log
    input wire tgt_done_in, // target completed the forwarded access
    input wire [`PFIC_DATA_W-1:0] tgt_rdata_in, // target read data
    output reg tgt_valid_out, // access forwarded to target
    output reg [`PFIC_ADDR_W-1:0] tgt_addr_out, // forwarded address
    output reg tgt_write_out, // forwarded direction
    output reg [`PFIC_DATA_W-1:0] tgt_wdata_out, // forwarded write data
    output reg resp_valid_out, // response pulse to initiator
    output reg resp_err_out, // response carries an error
    output reg [`PFIC_DATA_W-1:0] resp_rdata_out, // read data to initiator
    output reg [MASK_W-1:0] mask_out, // current membership vector
    output reg log_valid_out, // a violation has been logged
    output reg [`PFIC_SEG_TAG_W-1:0] log_tag_out, // doubled tag of first violation
    output reg [`PFIC_ADDR_W-1:0] log_addr_out, // address of first violation
    output reg log_write_out, // direction of first violation
    output reg busy_out // an access is in progress
);

////////////////////////////////////////////////////////////////////////////////

localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_FWD = 3'b010;
localparam [2:0] ST_RESP = 3'b100;

// every nominal tag value, including the three above 0xC
localparam TAG_N = 1 << `PFIC_TAG_W;

reg [2:0] state_r;
reg [2:0] state_nxt;
reg [`PFIC_SEG_TAG_W-1:0] seg_tag;
reg permit;
reg take;
reg deny;
reg log_valid_nxt;
reg [`PFIC_SEG_TAG_W-1:0] log_tag_nxt;
reg [`PFIC_ADDR_W-1:0] log_addr_nxt;
reg log_write_nxt;
reg [MASK_W-1:0] mask_nxt;
wire [TAG_N-1:0] tag_admit;

// segment tag: nominal shifted left one place
function [`PFIC_SEG_TAG_W-1:0] seg_tag_of;
    input [`PFIC_TAG_W-1:0] tag;
    begin
        seg_tag_of = {1'b0, tag} << `PFIC_TAG_SHIFT; // RL1 RL7
    end
endfunction

// a taken request whose membership bit is clear
function deny_of;
    input taken;
    input admitted;
    begin
        deny_of = taken && !admitted;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////

// tag k reads bit 2k only; odd bits are stored but never consulted
genvar g;
generate
    for (g = 0; g < TAG_N; g = g + 1) begin : g_admit
        assign tag_admit[g] = mask_out[g << `PFIC_TAG_SHIFT]; // RL2 RL7
    end
endgenerate

always @* begin
    seg_tag = seg_tag_of(req_tag_in); // RL1
    permit = tag_admit[req_tag_in]; // RL2 RL5
    take = (state_r == ST_IDLE) && req_valid_in;
    deny = deny_of(take, permit); // RL8
end

////////////////////////////////////////////////////////////////////////////////

always @* begin
    state_nxt = state_r;
    case (state_r)
        ST_IDLE: begin
            if (take) begin
                state_nxt = permit ? ST_FWD : ST_RESP; // RL8
            end
        end
        ST_FWD: begin
            if (tgt_done_in) begin
                state_nxt = ST_RESP;
            end
        end
        ST_RESP: begin
            state_nxt = ST_IDLE;
        end
        default: begin
            state_nxt = ST_IDLE;
        end
    endcase
end

always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        state_r <= ST_IDLE;
    end else begin
        state_r <= state_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////

// only permitted accesses ever reach the target
always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        tgt_valid_out <= 1'b0;
        tgt_addr_out <= 32'h00000000;
        tgt_write_out <= 1'b0;
        tgt_wdata_out <= 32'h00000000;
    end else if (take && permit) begin
        tgt_valid_out <= 1'b1; // RL2
        tgt_addr_out <= req_addr_in;
        tgt_write_out <= req_write_in;
        tgt_wdata_out <= req_wdata_in;
    end else if (state_r != ST_FWD || tgt_done_in) begin
        tgt_valid_out <= 1'b0;
    end
end

// errors and writes answer zero data so no stale read leaks out
always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        resp_valid_out <= 1'b0;
        resp_err_out <= 1'b0;
        resp_rdata_out <= 32'h00000000;
    end else begin
        resp_valid_out <= (state_r == ST_RESP); // RL8
        if (take) begin
            resp_err_out <= deny; // RL8
            resp_rdata_out <= 32'h00000000;
        end else if (state_r == ST_FWD && tgt_done_in && !tgt_write_out) begin
            resp_rdata_out <= tgt_rdata_in;
        end
    end
end

// busy spans take to response, so requests in flight are ignored
always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        busy_out <= 1'b0;
    end else if (take) begin
        busy_out <= 1'b1;
    end else if (state_r != ST_FWD) begin
        busy_out <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////

// membership vector; a write applies from the next taken request
always @* begin
    mask_nxt = mask_out;
    if (mask_wr_in) begin
        mask_nxt = mask_wdata_in; // RL6
    end
end

always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        mask_out <= MASK_RST; // RL4 RL5
    end else begin
        mask_out <= mask_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////

// log keeps the first violation; a new violation wins over a clear
always @* begin
    log_valid_nxt = log_valid_out;
    log_tag_nxt = log_tag_out;
    log_addr_nxt = log_addr_out;
    log_write_nxt = log_write_out;
    if (deny && (!log_valid_out || log_clr_in)) begin
        log_valid_nxt = 1'b1;
        log_tag_nxt = seg_tag; // RL3
        log_addr_nxt = req_addr_in;
        log_write_nxt = req_write_in;
    end else if (log_clr_in) begin
        log_valid_nxt = 1'b0;
    end
end

always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        log_valid_out <= 1'b0;
        log_tag_out <= 5'h00;
        log_addr_out <= 32'h00000000;
        log_write_out <= 1'b0;
    end else begin
        log_valid_out <= log_valid_nxt;
        log_tag_out <= log_tag_nxt;
        log_addr_out <= log_addr_nxt;
        log_write_out <= log_write_nxt;
    end
end

endmodule // pfic_firewall

// ### pfic_consts.vh
`ifndef PFIC_CONSTS_VH
`define PFIC_CONSTS_VH

// nominal initiator tag width (values 0x0..0xC)
`define PFIC_TAG_W 4
// tag as seen on this segment, one bit wider
`define PFIC_SEG_TAG_W 5
// left shift applied to the tag on this segment
`define PFIC_TAG_SHIFT 1
// membership vector width
`define PFIC_MASK_W 32
// reset membership: upper 16 bits clear
`define PFIC_MASK_RST 32'h0000FFFF
// address width of the access path
`define PFIC_ADDR_W 32
// data width of the access path
`define PFIC_DATA_W 32

`endif

// ### pfic_fw_chk_asserts.sv
`timescale 1ns/1ps
module pfic_fw_chk (
    input logic clk_in,
    input logic rst_n_in,
    input logic req_valid_in,
    input logic [3:0] req_tag_in,
    input logic tgt_done_in,
    input logic log_clr_in,
    input logic busy_out,
    input logic tgt_valid_out,
    input logic resp_valid_out,
    input logic resp_err_out,
    input logic [31:0] mask_out,
    input logic log_valid_out,
    input logic [4:0] log_tag_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire tk = req_valid_in && !busy_out;
    wire ok = mask_out[{req_tag_in, 1'b0}];
    a_deny_path: assert property (tk && !ok |=> !tgt_valid_out && resp_err_out ##1 resp_valid_out)
        else $error("denied access misrouted");
    a_permit_fwd: assert property (tk && ok |=> tgt_valid_out && !resp_err_out)
        else $error("permitted access not forwarded");
    a_done_resp: assert property (tgt_valid_out && tgt_done_in |=> !tgt_valid_out ##1 resp_valid_out)
        else $error("no response after target done");
    a_log_tag: assert property (tk && !ok && !log_valid_out |=> log_valid_out && log_tag_out == {$past(req_tag_in), 1'b0})
        else $error("violation tag not logged doubled");
    a_log_hold: assert property (log_valid_out && !log_clr_in |=> log_valid_out && $stable(log_tag_out))
        else $error("logged violation lost");
    a_rst_mask: assert property ($rose(rst_n_in) |-> mask_out == 32'h0000FFFF)
        else $error("membership reset value wrong");
    a_high_deny: assert property (tk && req_tag_in[3] && mask_out[31:16] == 16'h0 |=> resp_err_out)
        else $error("high tag admitted");
    a_resp_pulse: assert property (resp_valid_out |-> !busy_out ##1 !resp_valid_out)
        else $error("response not a single pulse");
endmodule // pfic_fw_chk

// ### pfic_target_model.sv
`timescale 1ns/1ps
module pfic_target_model (
    input logic clk_in, // clock
    input logic fwd_valid_in, // forwarded access
    input logic [31:0] fwd_addr_in, // forwarded address
    output logic done_out, // completion pulse
    output logic [31:0] rdata_out // read data
);
    int cnt = 0;
    initial begin
        done_out = 0;
        rdata_out = 0;
        forever begin
            @(posedge clk_in) #1;
            // released data scrambled so stale values never match
            if (done_out) begin
                done_out = 0;
                rdata_out = ~rdata_out;
            end else if (fwd_valid_in && cnt == fwd_addr_in[1:0]) begin
                done_out = 1;
                rdata_out = fwd_addr_in + 1;
                cnt = 0;
            end else if (fwd_valid_in) cnt++;
        end
    end
endmodule // pfic_target_model

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk_in, rst_n_in, req_valid_in, req_write_in, mask_wr_in, log_clr_in, tgt_done_in, exp_lw;
    logic [3:0] req_tag_in;
    logic [31:0] req_addr_in, req_wdata_in, mask_wdata_in, tgt_rdata_in, exp_mask, exp_la;
    wire tgt_valid_out, tgt_write_out, resp_valid_out, resp_err_out, log_valid_out, log_write_out, busy_out;
    wire [31:0] tgt_addr_out, tgt_wdata_out, resp_rdata_out, mask_out, log_addr_out;
    wire [4:0] log_tag_out;
    int miscompares = 0, n_tests = 0, exp_log = -1, i, j, k;
    logic [15:0] lfsr = 16'hEE67;
    pfic_firewall i_dut (.*);
    pfic_target_model i_tgt (.clk_in(clk_in), .fwd_valid_in(tgt_valid_out), .fwd_addr_in(tgt_addr_out),
        .done_out(tgt_done_in), .rdata_out(tgt_rdata_in));
    function logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task wrap_up;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task acc(input logic [3:0] t, input logic clr);
        logic er;
        lfsr = nxt(lfsr);
        er = !exp_mask[2 * t];
        req_tag_in = t;
        req_write_in = lfsr[0];
        req_addr_in = {16'h0, lfsr};
        req_wdata_in = ~req_addr_in;
        req_valid_in = 1;
        log_clr_in = clr;
        @(posedge clk_in) #1;
        req_valid_in = 0;
        log_clr_in = 0;
        if (clr) exp_log = -1;
        if (er && exp_log < 0) begin
            exp_log = 2 * t;
            exp_la = req_addr_in;
            exp_lw = req_write_in;
        end
        chk("busy", busy_out, 1);
        chk("fwd", tgt_valid_out, !er);
        if (!er) begin
            chk("taddr", tgt_addr_out, req_addr_in);
            chk("twr", tgt_write_out, req_write_in);
            chk("twd", tgt_wdata_out, req_wdata_in);
        end
        chk("logv", log_valid_out, exp_log >= 0);
        if (exp_log >= 0) begin
            chk("log", log_tag_out, exp_log);
            chk("laddr", log_addr_out, exp_la);
            chk("lwr", log_write_out, exp_lw);
        end
        for (j = 0; j < 20 && resp_valid_out !== 1'b1; j++) @(posedge clk_in) #1;
        chk("resp", resp_valid_out, 1);
        chk("err", resp_err_out, er);
        chk("rdata", resp_rdata_out, (er || req_write_in) ? 0 : req_addr_in + 1);
    endtask
    initial begin
        clk_in = 0;
        forever #25 clk_in = ~clk_in;
    end
    initial begin
        {rst_n_in, req_valid_in, req_write_in, mask_wr_in, log_clr_in, req_tag_in} = 0;
        {req_addr_in, req_wdata_in, mask_wdata_in} = 0;
        exp_mask = 32'h0000FFFF;
        repeat (5) @(posedge clk_in);
        #1 rst_n_in = 1;
        chk("mask", mask_out, exp_mask);
        for (i = 0; i < 26; i++) acc(i % 13, i == 14 || i == 25);
        for (i = 0; i < 4; i++) begin
            log_clr_in = 1;
            @(posedge clk_in) #1 log_clr_in = 0;
            exp_log = -1;
            chk("logv", log_valid_out, 0);
            lfsr = nxt(lfsr);
            // first pass even bits 0..24 only: every nominal tag admitted; later passes use random masks
            exp_mask = (i == 0) ? 32'h01555555 : {lfsr, nxt(lfsr)};
            mask_wdata_in = exp_mask;
            mask_wr_in = 1;
            @(posedge clk_in) #1 mask_wr_in = 0;
            chk("mask", mask_out, exp_mask);
            for (k = 0; k < 13; k++) acc(k, 0);
        end
        // mid-run reset must bring back the narrow default membership
        rst_n_in = 0;
        @(posedge clk_in) #1;
        rst_n_in = 1;
        exp_mask = 32'h0000FFFF;
        exp_log = -1;
        chk("mask", mask_out, exp_mask);
        chk("logv", log_valid_out, 0);
        chk("busy", busy_out, 0);
        acc(8, 0);
        acc(4, 0);
        wrap_up;
    end
    initial begin
        #100000;
        miscompares++;
        wrap_up;
    end
endmodule // tb_top
bind pfic_firewall pfic_fw_chk i_chk (.*);
